/* dccf_pkg.sv */
// constants, codes and helper functions shared by both framer ends
// assumes a single 250 MHz clock and nibble-wide payload transfer
package dccf_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] NUM_ROWS      = 4'd12;
  localparam logic [3:0] LAST_ROW      = 4'd11;
  localparam logic [5:0] POI_BYTE      = 6'd2;
  localparam logic [5:0] POH_BYTE      = 6'd3;
  localparam logic [5:0] CELL_FIRST    = 6'd4;
  localparam logic [5:0] LAST_BYTE     = 6'd56;
  localparam logic [3:0] TRAILER_SHORT = 4'd13;
  localparam logic [3:0] TRAILER_LONG  = 4'd14;
  localparam logic [3:0] ROW_B1        = 4'd7;
  localparam logic [3:0] ROW_G1        = 4'd8;
  localparam logic [3:0] ROW_C1        = 4'd11;

  // ----------------------------------------------------------------
  // octet and nibble codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FIRST_ALIGN_OCTET  = 8'hF6;
  localparam logic [7:0]  SECOND_ALIGN_OCTET = 8'h28;
  localparam logic [15:0] ALIGN_WORD         = 16'hF628;
  localparam logic [7:0]  C1_PHASE1          = 8'hFF;
  localparam logic [7:0]  C1_PHASE2          = 8'h00;
  localparam logic [7:0]  C1_PHASE3_NOSTUFF  = 8'h66;
  localparam logic [7:0]  C1_PHASE3_STUFF    = 8'h99;
  localparam logic [7:0]  GROWTH_OCTET       = 8'h00;
  localparam logic [3:0]  TRAILER_NIBBLE     = 4'hC;
  localparam logic [3:0]  FAR_END_ERROR_COUNT_NONE          = 4'hF;
  localparam logic [3:0]  FAR_END_ERROR_COUNT_MAX           = 4'h8;
  localparam logic [7:0]  IDLE_HDR_LAST      = 8'h01;
  localparam logic [7:0]  IDLE_HEC           = 8'h52;
  localparam logic [7:0]  IDLE_FILL          = 8'h6A;

  // ----------------------------------------------------------------
  // alarm timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_PS  = 64'd4000;
  localparam longint unsigned RAI_SET_MS     = 64'd2000;
  localparam longint unsigned RAI_CLEAR_MS   = 64'd15000;
  localparam longint unsigned RAI_SET_CYC    = (RAI_SET_MS * 64'd1000000000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
  localparam longint unsigned RAI_CLEAR_CYC  = (RAI_CLEAR_MS * 64'd1000000000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
  localparam logic [3:0]      RAI_FRAMES     = 4'd10;
  localparam logic [1:0]      LOF_ROWS       = 2'd2;

  typedef enum logic [1:0] {DCCF_HUNT, DCCF_PRESYNC, DCCF_SYNC} dccf_rx_state_type;

  // row identifier code for each row, top row first
  function automatic logic [7:0] dccf_row_code(input logic [3:0] row);
    logic [7:0] c;
    c = 8'h00;
    unique case (row)
      4'd0:    c = 8'h2C;
      4'd1:    c = 8'h29;
      4'd2:    c = 8'h25;
      4'd3:    c = 8'h20;
      4'd4:    c = 8'h1C;
      4'd5:    c = 8'h19;
      4'd6:    c = 8'h15;
      4'd7:    c = 8'h10;
      4'd8:    c = 8'h0D;
      4'd9:    c = 8'h08;
      4'd10:   c = 8'h04;
      4'd11:   c = 8'h01;
      default: c = 8'h00;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] dccf_popcount8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'd0;
    for (int i = 0; i < 8; i++)
      n = n + {3'd0, v[i]};
    return n;
  endfunction

endpackage

/* dccf_link_if.sv */
// payload nibble stream between the two convergence framer ends
// assumes both ends share mclk; the ds3 line framer sits outside
`timescale 1ns/1ps
interface dccf_link_if;
  logic [3:0] nib;
  logic       nib_valid;
  logic       cbit_mode;

  modport tx_end (output nib, output nib_valid, output cbit_mode);
  modport rx_end (input nib, input nib_valid, input cbit_mode);
endinterface

/* dccf_tx_end.sv */
// transmit convergence framer: cells in, payload nibbles out
// assumes pay_slot pulses once per ds3 payload nibble position
`timescale 1ns/1ps

// Summary of operation
// - C-bit parity default, clear-channel fallback selectable
// - each cell goes into a frame slot
// - twelve rows, four overhead octets, one cell
// - frame nibble aligned, free of ds3 framing
// - every payload slot carries data, never stuff
// - rows top down, octets msb first
// - rows start with two alignment octets
// - parity covers path overhead octet and cells, previous frame
// - per-bit even parity, eight results
// - three-frame cycle, stuff only in third
// - trailer 13, 14, then 13 or 14
// - cycle octet encodes phase and stuff
// - status octet: error count, alarm, spare
// - report previous frame errors, else 1111
// - invalid received error counts mean zero
// - alarm bit after soak, cleared after absence
// - alarm declared after ten equal frames
// - third octet carries fixed row code
// - receiver ignores unassigned overhead octets
// - growth octets sent zero, ignored received
// - trailer nibbles are 1100
// - find alignment, then take cells directly
module dccf_tx_end
  import dccf_pkg::*;
#(
  parameter logic [31:0] RAI_SET_COUNT   = 32'(dccf_pkg::RAI_SET_CYC),
  parameter logic [31:0] RAI_CLEAR_COUNT = 32'(dccf_pkg::RAI_CLEAR_CYC)
)(
  // clock and reset
  input  logic             mclk,
  input  logic             rst_n,
  // line side
  dccf_link_if.tx_end      link,
  // payload timing and framing control
  input  logic             pay_slot,
  input  logic             stuff_req,
  input  logic             clear_channel,
  // local receiver report and alarm source
  input  logic             err_report,
  input  logic [3:0]       err_count,
  input  logic             incoming_failure,
  output logic             rai_sent,
  // cell byte input
  input  logic [7:0]       cell_byte,
  input  logic             cell_valid,
  output logic             cell_ready
);
  import dccf_pkg::*;

  // ----------------------------------------------------------------
  // two-entry cell byte buffer
  // ----------------------------------------------------------------
  logic [7:0] buf_mem [2];
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic [1:0] buf_cnt_q;
  logic       push;
  logic       pop;

  assign cell_ready = (buf_cnt_q != 2'd2);
  assign push       = cell_valid && cell_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      buf_mem[wr_ptr_q] <= cell_byte;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      buf_cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // frame position
  // ----------------------------------------------------------------
  logic [3:0] row_q;
  logic [5:0] byte_q;
  logic       half_q;
  logic       in_trl_q;
  logic [3:0] trl_q;
  logic [1:0] phase_q;
  logic       stuff_q;
  logic       idle_q;
  logic [3:0] trl_len;
  logic       frame_end;
  logic       idle_now;

  assign trl_len   = (phase_q == 2'd1 || (phase_q == 2'd2 && stuff_q)) ? TRAILER_LONG : TRAILER_SHORT;
  assign frame_end = pay_slot && in_trl_q && (trl_q == trl_len - 4'd1);
  assign idle_now  = (byte_q == CELL_FIRST) ? (buf_cnt_q == 2'd0) : idle_q;
  // a cell that runs dry mid-slot is padded with zero octets
  assign pop       = pay_slot && !in_trl_q && !half_q && byte_q >= CELL_FIRST && !idle_now
                     && buf_cnt_q != 2'd0;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_q    <= 4'd0;
      byte_q   <= 6'd0;
      half_q   <= 1'b0;
      in_trl_q <= 1'b0;
      trl_q    <= 4'd0;
    end
    else if (pay_slot)
    begin
      if (in_trl_q)
      begin
        if (frame_end)
        begin
          in_trl_q <= 1'b0;
          trl_q    <= 4'd0;
          row_q    <= 4'd0;
        end
        else
          trl_q <= trl_q + 4'd1;
      end
      else if (!half_q)
        half_q <= 1'b1;
      else
      begin
        half_q <= 1'b0;
        if (byte_q == LAST_BYTE)
        begin
          byte_q <= 6'd0;
          if (row_q == LAST_ROW)
            in_trl_q <= 1'b1;
          else
            row_q <= row_q + 4'd1;
        end
        else
          byte_q <= byte_q + 6'd1;
      end
    end
  end

  // stuff cycle advances once per frame
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= 2'd0;
      stuff_q <= 1'b0;
    end
    else if (frame_end)
    begin
      phase_q <= (phase_q == 2'd2) ? 2'd0 : phase_q + 2'd1;
      stuff_q <= (phase_q == 2'd1) ? stuff_req : 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      idle_q <= 1'b0;
    else if (pay_slot && !in_trl_q && !half_q && byte_q == CELL_FIRST)
      idle_q <= idle_now;
  end

  // ----------------------------------------------------------------
  // overhead and octet selection
  // ----------------------------------------------------------------
  logic [7:0] bip_acc_q;
  logic [7:0] bip_prev_q;
  logic [3:0] far_end_error_count_q;
  logic       rai_q;
  logic [7:0] path_overhead_octet;
  logic [7:0] cur_byte;
  logic [7:0] cell_oct;
  logic [5:0] cell_idx;

  always_comb
  begin
    unique case (row_q)
      ROW_B1:  path_overhead_octet = bip_prev_q;
      ROW_G1:  path_overhead_octet = {far_end_error_count_q, rai_q, 3'b000};
      ROW_C1:  path_overhead_octet = (phase_q == 2'd0) ? C1_PHASE1 : (phase_q == 2'd1) ? C1_PHASE2 :
                     stuff_q ? C1_PHASE3_STUFF : C1_PHASE3_NOSTUFF;
      default: path_overhead_octet = GROWTH_OCTET;
    endcase
  end

  assign cell_idx = byte_q - CELL_FIRST;

  always_comb
  begin
    cell_oct = 8'h00;
    if (idle_now)
      cell_oct = (cell_idx == 6'd3) ? IDLE_HDR_LAST : (cell_idx == 6'd4) ? IDLE_HEC :
                 (cell_idx > 6'd4) ? IDLE_FILL : 8'h00;
    else if (buf_cnt_q != 2'd0)
      cell_oct = buf_mem[rd_ptr_q];
  end

  always_comb
  begin
    unique case (byte_q)
      6'd0:     cur_byte = FIRST_ALIGN_OCTET;
      6'd1:     cur_byte = SECOND_ALIGN_OCTET;
      POI_BYTE: cur_byte = dccf_row_code(row_q);
      POH_BYTE: cur_byte = path_overhead_octet;
      default:  cur_byte = cell_oct;
    endcase
  end

  // ----------------------------------------------------------------
  // nibble output
  // ----------------------------------------------------------------
  logic [3:0] nib_q;
  logic       nib_valid_q;
  logic [3:0] lo_hold_q;
  logic       cbit_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nib_q       <= 4'd0;
      nib_valid_q <= 1'b0;
      lo_hold_q   <= 4'd0;
    end
    else
    begin
      nib_valid_q <= pay_slot;
      if (pay_slot)
      begin
        if (in_trl_q)
          nib_q <= TRAILER_NIBBLE;
        else if (!half_q)
        begin
          nib_q     <= cur_byte[7:4];
          lo_hold_q <= cur_byte[3:0];
        end
        else
          nib_q <= lo_hold_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cbit_q <= 1'b1;
    else
      cbit_q <= !clear_channel;
  end

  assign link.nib       = nib_q;
  assign link.nib_valid = nib_valid_q;
  assign link.cbit_mode = cbit_q;

  // ----------------------------------------------------------------
  // parity over overhead octet and cell
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bip_acc_q  <= 8'h00;
      bip_prev_q <= 8'h00;
    end
    else if (frame_end)
    begin
      bip_prev_q <= bip_acc_q;
      bip_acc_q  <= 8'h00;
    end
    else if (pay_slot && !in_trl_q && !half_q && byte_q >= POH_BYTE)
      bip_acc_q <= bip_acc_q ^ cur_byte;
  end

  // ----------------------------------------------------------------
  // path status: error count and remote alarm
  // ----------------------------------------------------------------
  logic        fail_s1_q;
  logic        fail_s2_q;
  logic        fail_s3_q;
  logic        fail_q;
  logic [31:0] soak_q;

  // 1111 until the local receiver has produced a first count
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      far_end_error_count_q <= FAR_END_ERROR_COUNT_NONE;
    else if (err_report)
      far_end_error_count_q <= (err_count > FAR_END_ERROR_COUNT_MAX) ? FAR_END_ERROR_COUNT_MAX : err_count;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
      fail_s3_q <= 1'b0;
      fail_q    <= 1'b0;
    end
    else
    begin
      fail_s1_q <= incoming_failure;
      fail_s2_q <= fail_s1_q;
      fail_s3_q <= fail_s2_q;
      if (fail_s2_q == fail_s3_q)
        fail_q <= fail_s3_q;
    end
  end

  // soak counter restarts whenever the condition breaks
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soak_q <= 32'd0;
      rai_q  <= 1'b0;
    end
    else if (fail_q == rai_q)
      soak_q <= 32'd0;
    else if (soak_q == (rai_q ? RAI_CLEAR_COUNT : RAI_SET_COUNT) - 32'd1)
    begin
      soak_q <= 32'd0;
      rai_q  <= fail_q;
    end
    else
      soak_q <= soak_q + 32'd1;
  end

  assign rai_sent = rai_q;

endmodule

/* dccf_rx_end.sv */
// receive convergence framer: payload nibbles in, cells and status out
// assumes the link stream arrives on mclk from the peer transmit end
`timescale 1ns/1ps
module dccf_rx_end
  import dccf_pkg::*;
(
  // clock and reset
  input  logic       mclk,
  input  logic       rst_n,
  // line side
  dccf_link_if.rx_end link,
  // framing state
  output logic       in_frame,
  output logic       frame_lost,
  output logic       cbit_active,
  // cell byte output
  output logic [7:0] cell_byte,
  output logic       cell_valid,
  output logic       cell_sop,
  // parity and path status
  output logic       err_report,
  output logic [3:0] err_count,
  output logic       far_end_error_count_report,
  output logic [3:0] far_end_error_count_count,
  output logic       rai_detected
);
  import dccf_pkg::*;

  // ----------------------------------------------------------------
  // alignment hunt and frame position
  // ----------------------------------------------------------------
  dccf_rx_state_type state_q;
  logic [11:0] sh_q;
  logic [3:0]  hi_q;
  logic [3:0]  row_q;
  logic [5:0]  byte_q;
  logic        half_q;
  logic        in_trl_q;
  logic [3:0]  trl_q;
  logic [3:0]  trl_len_q;
  logic        row_bad_q;
  logic [1:0]  miss_q;
  logic        named_q;
  logic        lost_q;
  logic [7:0]  rx_byte;
  logic        byte_stb;
  logic        code_hit;
  logic [3:0]  code_row;

  assign rx_byte  = {hi_q, link.nib};
  assign byte_stb = link.nib_valid && state_q != DCCF_HUNT && !in_trl_q && half_q;

  always_comb
  begin
    code_hit = 1'b0;
    code_row = 4'd0;
    for (int r = 0; r < 12; r++)
      if (dccf_row_code(4'(r)) == rx_byte)
      begin
        code_hit = 1'b1;
        code_row = 4'(r);
      end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sh_q <= 12'd0;
    else if (link.nib_valid)
      sh_q <= {sh_q[7:0], link.nib};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= DCCF_HUNT;
      hi_q      <= 4'd0;
      row_q     <= 4'd0;
      byte_q    <= 6'd0;
      half_q    <= 1'b0;
      in_trl_q  <= 1'b0;
      trl_q     <= 4'd0;
      trl_len_q <= TRAILER_SHORT;
      row_bad_q <= 1'b0;
      miss_q    <= 2'd0;
      named_q   <= 1'b0;
      lost_q    <= 1'b0;
    end
    else
    begin
      lost_q <= 1'b0;
      if (link.nib_valid)
      begin
        if (state_q == DCCF_HUNT)
        begin
          if ({sh_q, link.nib} == ALIGN_WORD)
          begin
            state_q   <= DCCF_PRESYNC;
            byte_q    <= POI_BYTE;
            half_q    <= 1'b0;
            in_trl_q  <= 1'b0;
            row_bad_q <= 1'b0;
            miss_q    <= 2'd0;
            named_q   <= 1'b0;
          end
        end
        else if (in_trl_q)
        begin
          if (trl_q == trl_len_q - 4'd1)
          begin
            in_trl_q <= 1'b0;
            trl_q    <= 4'd0;
            row_q    <= 4'd0;
          end
          else
            trl_q <= trl_q + 4'd1;
        end
        else if (!half_q)
        begin
          hi_q   <= link.nib;
          half_q <= 1'b1;
        end
        else
        begin
          half_q <= 1'b0;
          unique case (byte_q)
            6'd0:     row_bad_q <= (rx_byte != FIRST_ALIGN_OCTET);
            6'd1:     row_bad_q <= row_bad_q || (rx_byte != SECOND_ALIGN_OCTET);
            POI_BYTE:
            begin
              if (state_q == DCCF_PRESYNC && row_bad_q)
                state_q <= DCCF_HUNT;
              else if (state_q == DCCF_PRESYNC && byte_q == POI_BYTE && !code_hit)
                state_q <= DCCF_HUNT;
              else if (state_q == DCCF_PRESYNC)
              begin
                // the first code names the row; row_q has moved on by the next row, so it must match
                row_q   <= code_row;
                named_q <= 1'b1;
                if (named_q && code_row == row_q)
                  state_q <= DCCF_SYNC;
              end
              else if (row_bad_q || rx_byte != dccf_row_code(row_q))
              begin
                miss_q <= miss_q + 2'd1;
                if (miss_q == LOF_ROWS - 2'd1)
                begin
                  state_q <= DCCF_HUNT;
                  lost_q  <= 1'b1;
                end
              end
              else
                miss_q <= 2'd0;
            end
            POH_BYTE:
              if (row_q == ROW_C1)
                trl_len_q <= (rx_byte == C1_PHASE2 || rx_byte == C1_PHASE3_STUFF) ? TRAILER_LONG : TRAILER_SHORT;
            default: ;
          endcase
          if (byte_q == LAST_BYTE)
          begin
            byte_q <= 6'd0;
            if (row_q == LAST_ROW)
              in_trl_q <= 1'b1;
            else
              row_q <= row_q + 4'd1;
          end
          else
            byte_q <= byte_q + 6'd1;
        end
      end
    end
  end

  assign in_frame    = (state_q == DCCF_SYNC);
  assign frame_lost  = lost_q;
  assign cbit_active = link.cbit_mode;

  // ----------------------------------------------------------------
  // cell extraction from fixed slots
  // ----------------------------------------------------------------
  // the line cannot be stalled, so the cell sink must take every byte
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cell_byte  <= 8'h00;
      cell_valid <= 1'b0;
      cell_sop   <= 1'b0;
    end
    else
    begin
      cell_valid <= byte_stb && state_q == DCCF_SYNC && byte_q >= CELL_FIRST;
      cell_sop   <= byte_stb && state_q == DCCF_SYNC && byte_q == CELL_FIRST;
      if (byte_stb)
        cell_byte <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // parity check and path status
  // ----------------------------------------------------------------
  logic [7:0] bip_acc_q;
  logic [7:0] bip_prev_q;
  logic       prev_ok_q;
  logic       full_q;
  logic       frame_end;
  logic [3:0] rai_cnt_q;
  logic       rai_q;

  assign frame_end = link.nib_valid && in_trl_q && trl_q == trl_len_q - 4'd1;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bip_acc_q  <= 8'h00;
      bip_prev_q <= 8'h00;
      prev_ok_q  <= 1'b0;
      full_q     <= 1'b0;
    end
    else if (state_q == DCCF_HUNT)
    begin
      prev_ok_q <= 1'b0;
      full_q    <= 1'b0;
    end
    else if (frame_end)
    begin
      bip_prev_q <= bip_acc_q;
      bip_acc_q  <= 8'h00;
      // the frame of lock was summed from mid-frame, so it is never compared
      prev_ok_q  <= (state_q == DCCF_SYNC) && full_q;
      full_q     <= (state_q == DCCF_SYNC);
    end
    else if (byte_stb && byte_q >= POH_BYTE)
      bip_acc_q <= bip_acc_q ^ rx_byte;
  end

  // unassigned and growth overhead octets are never examined
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_report  <= 1'b0;
      err_count   <= 4'd0;
      far_end_error_count_report <= 1'b0;
      far_end_error_count_count  <= 4'd0;
    end
    else
    begin
      err_report  <= 1'b0;
      far_end_error_count_report <= 1'b0;
      if (byte_stb && byte_q == POH_BYTE && state_q == DCCF_SYNC)
      begin
        if (row_q == ROW_B1 && prev_ok_q)
        begin
          err_report <= 1'b1;
          err_count  <= dccf_popcount8(rx_byte ^ bip_prev_q);
        end
        if (row_q == ROW_G1 && rx_byte[7:4] != FAR_END_ERROR_COUNT_NONE)
        begin
          far_end_error_count_report <= 1'b1;
          far_end_error_count_count  <= (rx_byte[7:4] > FAR_END_ERROR_COUNT_MAX) ? 4'd0 : rx_byte[7:4];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rai_cnt_q <= 4'd0;
      rai_q     <= 1'b0;
    end
    else if (byte_stb && byte_q == POH_BYTE && row_q == ROW_G1 && state_q == DCCF_SYNC)
    begin
      if (rx_byte[3] == rai_q)
        rai_cnt_q <= 4'd0;
      else if (rai_cnt_q == RAI_FRAMES - 4'd1)
      begin
        rai_cnt_q <= 4'd0;
        rai_q     <= rx_byte[3];
      end
      else
        rai_cnt_q <= rai_cnt_q + 4'd1;
    end
  end

  assign rai_detected = rai_q;

endmodule

/* dccf_link_sva.sv */
// link stream checker for the framer pair
// assumes tx and rx ends share mclk and the link interface
`timescale 1ns/1ps
module dccf_link_sva (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // link
  input wire logic [3:0] nib,
  input wire logic       nib_valid,
  input wire logic       cbit_mode
);
  logic [15:0] h_q;
  logic [3:0]  h4_q;
  logic [7:0]  c1_q;
  logic [7:0]  c1_now;
  logic [4:0]  run_q;
  logic        seen_q;
  logic        cap;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // low nibble of the cycle octet; the last row's cell sits between it and the trailer
  assign c1_now = {h_q[3:0], nib};
  assign cap    = nib_valid && {h4_q, h_q[15:4]} == 16'h2801;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      h_q  <= '0;
      h4_q <= '0;
    end
    else if (nib_valid)
    begin
      h_q  <= {h_q[11:0], nib};
      h4_q <= h_q[15:12];
    end

  // trailer run is only trusted between a cycle octet and the next frame
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      c1_q   <= '0;
      run_q  <= '0;
      seen_q <= 1'b0;
    end
    else if (cap)
    begin
      c1_q   <= c1_now;
      run_q  <= 5'd0;
      seen_q <= 1'b1;
    end
    else if (nib_valid && nib == 4'hC)
      run_q <= run_q + 5'd1;

  a_second_align: assert property (nib_valid && h_q[11:0] == 12'hCF6 |-> nib == 4'h2)
    else $error("second align nibble wrong");
  a_row_code: assert property (nib_valid && h_q == 16'hF628 |-> nib <= 4'h2)
    else $error("row code out of range");
  a_growth_zero: assert property (nib_valid && h_q == 16'h282C |-> nib == 4'h0)
    else $error("growth octet not zero");
  a_status_count: assert property (nib_valid && h_q == 16'h280D |-> nib <= 4'h8 || nib == 4'hF)
    else $error("far end count illegal");
  a_trailer_end: assert property (nib_valid && h_q[11:0] == 12'hCCC && nib != 4'hC |-> nib == 4'hF)
    else $error("trailer nibble wrong");
  a_cycle_code: assert property (cap |-> c1_now inside {8'hFF, 8'h00, 8'h66, 8'h99})
    else $error("cycle octet illegal");
  a_cycle_order: assert property (cap && seen_q |-> (c1_q == 8'hFF) ? c1_now == 8'h00 :
    (c1_q == 8'h00) ? (c1_now == 8'h66 || c1_now == 8'h99) : c1_now == 8'hFF)
    else $error("cycle phase out of order");
  a_trailer_len: assert property (nib_valid && seen_q && h_q[3:0] == 4'hC && nib == 4'hF
    |-> run_q == ((c1_q == 8'h00 || c1_q == 8'h99) ? 5'd14 : 5'd13))
    else $error("trailer length wrong");

  c_stuff: cover property (cap && c1_now == 8'h99);
  c_no_stuff: cover property (cap && c1_now == 8'h66);
  c_clear_channel: cover property (!cbit_mode);
  c_alarm_bit: cover property (nib_valid && h_q[15:4] == 12'h80D && nib[3]);
endmodule

/* tb.sv */
// testbench joining the tx and rx framer ends over one link
// assumes a clean link; alarm soak counts shortened to 20 and 40
`timescale 1ns/1ps
module tb;
  logic       mclk, rst_n, pay_slot, stuff_req, clear_channel, incoming_failure;
  logic [7:0] tx_byte, rx_byte;
  logic       tx_valid, cell_ready, rai_sent, in_frame, frame_lost, cbit_active;
  logic       rx_valid, rx_sop, err_report, far_end_error_count_report, rai_detected;
  logic [3:0] err_count, far_end_error_count_count;
  int         mismatches, compares, nb;

  dccf_link_if link ();
  dccf_tx_end #(.RAI_SET_COUNT(32'd20), .RAI_CLEAR_COUNT(32'd40)) u_dccf_tx_end (.mclk(mclk), .rst_n(rst_n),
    .link(link.tx_end), .pay_slot(pay_slot), .stuff_req(stuff_req), .clear_channel(clear_channel),
    .err_report(err_report), .err_count(err_count), .incoming_failure(incoming_failure),
    .rai_sent(rai_sent), .cell_byte(tx_byte), .cell_valid(tx_valid), .cell_ready(cell_ready));
  dccf_rx_end u_dccf_rx_end (.mclk(mclk), .rst_n(rst_n), .link(link.rx_end), .in_frame(in_frame),
    .frame_lost(frame_lost), .cbit_active(cbit_active), .cell_byte(rx_byte), .cell_valid(rx_valid),
    .cell_sop(rx_sop), .err_report(err_report), .err_count(err_count), .far_end_error_count_report(far_end_error_count_report),
    .far_end_error_count_count(far_end_error_count_count), .rai_detected(rai_detected));
  dccf_link_sva u_dccf_link_sva (.mclk(mclk), .rst_n(rst_n), .nib(link.nib), .nib_valid(link.nib_valid),
    .cbit_mode(link.cbit_mode));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // byte held until a rising edge with ready high; ready is settled at the falling edge
  task automatic send_byte(input logic [7:0] b);
    tx_byte = b;
    tx_valid = 1'b1;
    while (cell_ready !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
  endtask

  // bounded wait for a level, then compare
  task automatic expect_flag(input string what, ref logic f, input logic exp, input int cyc);
    repeat (cyc)
      if (f !== exp)
        @(negedge mclk);
    check(what, {7'd0, f}, {7'd0, exp});
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    #240000;
    mismatches++;
    results();
  end

  // feeder never runs dry, so the buffer spends most time full
  initial
  begin
    wait (rst_n === 1'b1);
    @(negedge mclk);
    forever send_byte(8'h11);
  end

  always @(negedge mclk)
  begin
    if (rx_valid === 1'b1)
    begin
      if (rx_sop === 1'b1 && nb > 0)
        check("cell length", 8'(nb), 8'd53);
      nb = (rx_sop === 1'b1) ? 1 : (nb > 0 ? nb + 1 : 0);
      check("cell byte", rx_byte, 8'h11);
    end
    if (err_report === 1'b1)
      check("parity errors", {4'h0, err_count}, 8'h00);
    if (far_end_error_count_report === 1'b1)
      check("far end errors", {4'h0, far_end_error_count_count}, 8'h00);
    if (frame_lost === 1'b1)
      check("frame lost", {7'd0, frame_lost}, 8'h00);
  end

  initial
  begin
    rst_n = 1'b0;
    pay_slot = 1'b0;
    stuff_req = 1'b1;
    clear_channel = 1'b0;
    incoming_failure = 1'b0;
    tx_byte = 8'h00;
    tx_valid = 1'b0;
    nb = 0;
    repeat (6) @(negedge mclk);
    check("reset cbit", {7'd0, link.cbit_mode}, 8'h01);
    check("reset ready", {7'd0, cell_ready}, 8'h01);
    rst_n = 1'b1;
    pay_slot = 1'b1;
    expect_flag("lock", in_frame, 1'b1, 4200);
    clear_channel = 1'b1;
    expect_flag("clear channel", cbit_active, 1'b0, 4);
    clear_channel = 1'b0;
    expect_flag("parity mode", cbit_active, 1'b1, 4);
    repeat (3000) @(negedge mclk);
    stuff_req = 1'b0;
    incoming_failure = 1'b1;
    expect_flag("alarm sent", rai_sent, 1'b1, 40);
    repeat (11000) @(negedge mclk);
    check("alarm early", {7'd0, rai_detected}, 8'h00);
    expect_flag("alarm seen", rai_detected, 1'b1, 5000);
    incoming_failure = 1'b0;
    expect_flag("alarm cleared", rai_sent, 1'b0, 60);
    expect_flag("alarm gone", rai_detected, 1'b0, 17000);
    check("still locked", {7'd0, in_frame}, 8'h01);
    results();
  end
endmodule
